// ===== rtl/dpis_datapath_init_sequencer.v
/*
 * Data path init sequencer: validates staged per-lane application codes,
 * copies them to the active set, steps the per-lane data path state
 * from deactivated through initializing to initialized, and raises the
 * sticky state-changed flags that drive the interrupt.
 * Assumes host-side register decode on the same clock delivers write
 * strobes and flag-read strobes as one-cycle pulses. Inputs share the
 * clock, so none passes a synchroniser here.
 * Limitation: one shared init timer; a lane released later delays the rest.
 */
// Behaviour
// - Apply-init write triggers validation of staged set 0 for selected lanes.
// - Valid: copy to active set, then init-pending bits, then config status last.
// - Deinit condition false moves lane from deactivated to initializing.
// - While initializing, init resources and clear init-pending bits.
// - Init done: enter initialized, set state-changed flags, raise interrupt.
// - Deinit mask resets to 00h; host writes FFh to hold paths deinitialized.
// - Power on loads default configuration into active and staged sets.

`timescale 1ns/1ps
`default_nettype none
`include "dpis_map.vh"

module dpis_datapath_init_sequencer (
    // Clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // Module state
    input wire module_ready_state_i,
    // Staged set 0 write port
    input wire staged_wr_i,
    input wire [2:0] staged_lane_i,
    input wire [`DPIS_APSEL_W-1:0] application_select_code_i,
    // Apply-init, deinit mask and flag read strobes
    input wire apply_init_wr_i,
    input wire [`DPIS_LANES-1:0] apply_init_lane_mask_i,
    input wire deinit_wr_i,
    input wire [`DPIS_LANES-1:0] lane_deinit_mask_i,
    input wire flag_rd_i,
    // Application codes the module supports, one bit per code
    input wire [15:0] supported_apps_i,
    // Status outputs
    output reg [`DPIS_LANES*`DPIS_APSEL_W-1:0] active_app_o,
    output reg [`DPIS_LANES*`DPIS_APSEL_W-1:0] staged_app_o,
    output reg [`DPIS_LANES-1:0] init_pending_bits_o,
    output reg [`DPIS_LANES*2-1:0] config_status_fields_o,
    output reg [`DPIS_LANES-1:0] lane_deinit_mask_o,
    output reg [`DPIS_LANES*2-1:0] path_state_o,
    output reg [`DPIS_LANES-1:0] path_state_changed_flag_o,
    output reg interrupt_o
);

    // Apply walk states
    localparam [1:0] AP_IDLE = 2'h0;
    localparam [1:0] AP_COPY = 2'h1;
    localparam [1:0] AP_PEND = 2'h2;
    localparam [1:0] AP_STAT = 2'h3;
    // Count fits in 8 bits; the slice keeps the width explicit
    localparam [31:0] INIT_CYC_FULL = `DPIS_INIT_CYC;
    localparam [7:0] INIT_CYC = INIT_CYC_FULL[7:0];

    reg [1:0] ap_state_r;
    reg [`DPIS_LANES-1:0] ap_mask_r;
    reg [`DPIS_LANES-1:0] ap_ok_r;
    reg [7:0] init_cnt_r;
    reg [`DPIS_LANES-1:0] set_flag_nxt;
    reg [`DPIS_LANES-1:0] ok_nxt;
    // One loop index per process keeps each variable single-driven
    integer i_ok;
    integer i_ap;
    integer i_fl;
    integer i_st;

    // Validation: each selected lane must carry a nonzero supported code
    always @* begin
        ok_nxt = {`DPIS_LANES{1'b0}};
        // Code 0 is never valid, whatever the supported mask says
        for (i_ok = 0; i_ok < `DPIS_LANES; i_ok = i_ok + 1) begin
            ok_nxt[i_ok] = (staged_app_o[i_ok*4 +: 4] != 4'h0) &&
                supported_apps_i[staged_app_o[i_ok*4 +: 4]];
        end
    end

    // Apply sequence walks copy, pending, status one step per cycle so
    // status is never seen updated before the active set.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ap_state_r <= AP_IDLE;
            ap_mask_r <= 8'h00;
            ap_ok_r <= 8'h00;
            active_app_o <= {`DPIS_LANES{`DPIS_DEFAULT_APSEL}};
            staged_app_o <= {`DPIS_LANES{`DPIS_DEFAULT_APSEL}};
            init_pending_bits_o <= 8'h00;
            config_status_fields_o <= 16'h0000;
        end else begin
            if (staged_wr_i && ap_state_r == AP_IDLE) begin
                staged_app_o[staged_lane_i*4 +: 4] <= application_select_code_i;
            end
            case (ap_state_r)
                AP_IDLE: begin
                    // A zero mask selects nothing and starts no walk
                    if (apply_init_wr_i && apply_init_lane_mask_i != 8'h00) begin
                        ap_mask_r <= apply_init_lane_mask_i;
                        ap_ok_r <= ok_nxt;
                        for (i_ap = 0; i_ap < `DPIS_LANES; i_ap = i_ap + 1) begin
                            if (apply_init_lane_mask_i[i_ap]) begin
                                config_status_fields_o[i_ap*2 +: 2] <= `DPIS_CS_BUSY;
                            end
                        end
                        ap_state_r <= AP_COPY;
                    end
                end
                AP_COPY: begin
                    for (i_ap = 0; i_ap < `DPIS_LANES; i_ap = i_ap + 1) begin
                        // Rejected lanes keep their active code
                        if (ap_mask_r[i_ap] && ap_ok_r[i_ap]) begin
                            active_app_o[i_ap*4 +: 4] <= staged_app_o[i_ap*4 +: 4];
                        end
                    end
                    ap_state_r <= AP_PEND;
                end
                AP_PEND: begin
                    ap_state_r <= AP_STAT;
                end
                AP_STAT: begin
                    for (i_ap = 0; i_ap < `DPIS_LANES; i_ap = i_ap + 1) begin
                        if (ap_mask_r[i_ap]) begin
                            config_status_fields_o[i_ap*2 +: 2] <= ap_ok_r[i_ap] ?
                                `DPIS_CS_ACCEPT : `DPIS_CS_REJECT;
                        end
                    end
                    ap_state_r <= AP_IDLE;
                end
                default: ap_state_r <= AP_IDLE;
            endcase
            // Pending set in the middle step, cleared while initializing
            // Clear has priority: pending drops one cycle after a lane enters initializing
            for (i_ap = 0; i_ap < `DPIS_LANES; i_ap = i_ap + 1) begin
                if (path_state_o[i_ap*2 +: 2] == `DPIS_ST_INIT) begin
                    init_pending_bits_o[i_ap] <= 1'b0;
                end else if (ap_state_r == AP_PEND && ap_mask_r[i_ap] && ap_ok_r[i_ap]) begin
                    init_pending_bits_o[i_ap] <= 1'b1;
                end
            end
        end
    end

    // Deinit mask register
    // Host merges its own lanes first; the whole mask is replaced here
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lane_deinit_mask_o <= `DPIS_DEINIT_RST;
        end else if (deinit_wr_i) begin
            lane_deinit_mask_o <= lane_deinit_mask_i;
        end
    end

    // Per-lane path state; one shared init timer, all lanes entering
    // together finish together. A later lane restarts the timer.
    always @* begin
        set_flag_nxt = 8'h00;
        for (i_fl = 0; i_fl < `DPIS_LANES; i_fl = i_fl + 1) begin
            if (path_state_o[i_fl*2 +: 2] == `DPIS_ST_INIT && init_cnt_r == 8'h01) begin
                set_flag_nxt[i_fl] = 1'b1;
            end
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            path_state_o <= 16'h0000;
            init_cnt_r <= 8'h00;
            path_state_changed_flag_o <= 8'h00;
            interrupt_o <= 1'b0;
        end else begin
            if (init_cnt_r != 8'h00) begin
                init_cnt_r <= init_cnt_r - 8'h01;
            end
            for (i_st = 0; i_st < `DPIS_LANES; i_st = i_st + 1) begin
                case (path_state_o[i_st*2 +: 2])
                    `DPIS_ST_DEACT: begin
                        // Deinit condition: not ready or lane held in deinit
                        if (module_ready_state_i && !lane_deinit_mask_o[i_st] &&
                                ap_state_r == AP_IDLE) begin
                            path_state_o[i_st*2 +: 2] <= `DPIS_ST_INIT;
                            init_cnt_r <= INIT_CYC;
                        end
                    end
                    `DPIS_ST_INIT: begin
                        if (set_flag_nxt[i_st]) begin
                            path_state_o[i_st*2 +: 2] <= `DPIS_ST_INITD;
                        end
                    end
                    `DPIS_ST_INITD: begin
                        // Deactivation is not handled; initialized lanes stay
                        path_state_o[i_st*2 +: 2] <= `DPIS_ST_INITD;
                    end
                    default: path_state_o[i_st*2 +: 2] <= `DPIS_ST_DEACT;
                endcase
            end
            // Set wins over a same-cycle flag read
            if (flag_rd_i) begin
                path_state_changed_flag_o <= set_flag_nxt;
            end else begin
                path_state_changed_flag_o <= path_state_changed_flag_o | set_flag_nxt;
            end
            // Interrupt follows the flag bits held after this edge
            interrupt_o <= (flag_rd_i ? set_flag_nxt :
                (path_state_changed_flag_o | set_flag_nxt)) != 8'h00;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/dpis_map.vh
/*
 * Constants for the data path init sequencer: lane count, field widths,
 * reset values, state codes, status codes and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DPIS_MAP_VH
`define DPIS_MAP_VH

`define DPIS_LANES 8
`define DPIS_APSEL_W 4
`define DPIS_DEINIT_RST 8'h00
`define DPIS_DEINIT_HOLD 8'hFF
`define DPIS_DEFAULT_APSEL 4'h1
`define DPIS_ST_DEACT 2'h0
`define DPIS_ST_INIT 2'h1
`define DPIS_ST_INITD 2'h2
`define DPIS_CS_UNDEF 2'h0
`define DPIS_CS_ACCEPT 2'h1
`define DPIS_CS_REJECT 2'h2
`define DPIS_CS_BUSY 2'h3
`define DPIS_INIT_TIME_NS 1000
`define DPIS_CLK_NS 50
`define DPIS_INIT_CYC ((`DPIS_INIT_TIME_NS + `DPIS_CLK_NS - 1) / `DPIS_CLK_NS)

`endif

// ===== verification/dpis_host_model.sv
/* Host model: management strobes toward the sequencer.
   Assumes calls from the bench just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dpis_host_model (
    input wire logic clk_sys_i,
    output logic staged_wr_i = 1'b0, apply_init_wr_i = 1'b0, deinit_wr_i = 1'b0,
    output logic flag_rd_i = 1'b0,
    output logic [2:0] staged_lane_i = 3'h0,
    output logic [3:0] application_select_code_i = 4'h0,
    output logic [7:0] apply_init_lane_mask_i = 8'h00, lane_deinit_mask_i = 8'h00
);
    // k: 0 staged code, 1 apply, 2 deinit mask, 3 flag read
    task automatic pulse(input int k, input logic [7:0] m, input logic [3:0] c);
        @(posedge clk_sys_i);
        #1 staged_lane_i = m[2:0];
        application_select_code_i = c;
        apply_init_lane_mask_i = m;
        lane_deinit_mask_i = m;
        {flag_rd_i, deinit_wr_i, apply_init_wr_i, staged_wr_i} = 4'h1 << k;
        @(posedge clk_sys_i);
        #1 {flag_rd_i, deinit_wr_i, apply_init_wr_i, staged_wr_i} = 4'h0;
    endtask
endmodule
`default_nettype wire

// ===== verification/dpis_seq_props.sv
/* Checker: apply walk, lane state steps and flags.
   Assumes it is bound onto the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module dpis_seq_props (
    input wire logic clk_sys_i, reset_n_i, module_ready_state_i,
    input wire logic apply_init_wr_i, deinit_wr_i, flag_rd_i, interrupt_o,
    input wire logic [7:0] apply_init_lane_mask_i, lane_deinit_mask_i, lane_deinit_mask_o,
    input wire logic [7:0] init_pending_bits_o, path_state_changed_flag_o,
    input wire logic [15:0] config_status_fields_o, path_state_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Lanes whose 2-bit field holds v
    function automatic logic [7:0] is2(input logic [15:0] f, input logic [1:0] v);
        for (int i = 0; i < 8; i++) is2[i] = (f[2*i+:2] == v);
    endfunction
    chk_apply_busy: assert property (apply_init_wr_i && |apply_init_lane_mask_i
        && is2(config_status_fields_o, 2'h3) == 8'h00
        |=> is2(config_status_fields_o, 2'h3) == $past(apply_init_lane_mask_i)) else $error("busy");
    chk_pending_first: assert property ((is2(config_status_fields_o, 2'h1)
        & $past(is2(config_status_fields_o, 2'h3)) & ~$past(init_pending_bits_o)) == 8'h00)
        else $error("status before pending");
    chk_enter_init: assert property ((is2(path_state_o, 2'h1) & $past(is2(path_state_o, 2'h0))
        & ($past(lane_deinit_mask_o) | {8{!$past(module_ready_state_i)}})) == 8'h00)
        else $error("init entered while held");
    chk_init_clears: assert property ((is2(path_state_o, 2'h1)
        & $past(is2(path_state_o, 2'h1)) & init_pending_bits_o) == 8'h00) else $error("pending");
    chk_init_time: assert property ((is2(path_state_o, 2'h2) & ~$past(is2(path_state_o, 2'h2))
        & ~$past(is2(path_state_o, 2'h1), 20)) == 8'h00) else $error("init too short");
    chk_flag_entry: assert property ((is2(path_state_o, 2'h2) & ~$past(is2(path_state_o, 2'h2))
        & ~path_state_changed_flag_o) == 8'h00) else $error("flag missing");
    chk_irq_flags: assert property (interrupt_o == |path_state_changed_flag_o)
        else $error("interrupt mismatch");
    chk_flag_read: assert property (flag_rd_i |=> path_state_changed_flag_o ==
        (is2(path_state_o, 2'h2) & ~$past(is2(path_state_o, 2'h2)))) else $error("flag read");
    chk_deinit_wr: assert property (deinit_wr_i |=>
        lane_deinit_mask_o == $past(lane_deinit_mask_i)) else $error("deinit write");
endmodule
bind dpis_datapath_init_sequencer dpis_seq_props u_props (.clk_sys_i, .reset_n_i,
    .module_ready_state_i, .apply_init_wr_i, .deinit_wr_i, .flag_rd_i, .interrupt_o,
    .apply_init_lane_mask_i, .lane_deinit_mask_i, .lane_deinit_mask_o, .init_pending_bits_o,
    .path_state_changed_flag_o, .config_status_fields_o, .path_state_o);
`default_nettype wire

// ===== verification/dpis_datapath_init_sequencer_bench.sv
/* Bench: random app code and lanes, apply, reject, init, flag read.
   Assumes the checker is bound onto the design. */
`timescale 1ns/1ps
`default_nettype none
module dpis_datapath_init_sequencer_bench;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, module_ready_state_i = 1'b0;
    logic staged_wr_i, apply_init_wr_i, deinit_wr_i, flag_rd_i, interrupt_o;
    logic [2:0] staged_lane_i;
    logic [3:0] application_select_code_i, code;
    logic [7:0] apply_init_lane_mask_i, lane_deinit_mask_i, m, init_pending_bits_o;
    logic [7:0] lane_deinit_mask_o, path_state_changed_flag_o;
    logic [15:0] supported_apps_i = 16'h0000, config_status_fields_o, path_state_o;
    logic [31:0] active_app_o, staged_app_o;
    int bad_count = 0, n_checks = 0, seed;
    always #25 clk_sys_i = ~clk_sys_i;
    dpis_datapath_init_sequencer uut (.clk_sys_i, .reset_n_i, .module_ready_state_i,
        .staged_wr_i, .staged_lane_i, .application_select_code_i, .apply_init_wr_i,
        .apply_init_lane_mask_i, .deinit_wr_i, .lane_deinit_mask_i, .flag_rd_i,
        .supported_apps_i, .active_app_o, .staged_app_o, .init_pending_bits_o,
        .config_status_fields_o, .lane_deinit_mask_o, .path_state_o,
        .path_state_changed_flag_o, .interrupt_o);
    dpis_host_model h (.clk_sys_i, .staged_wr_i, .staged_lane_i, .application_select_code_i,
        .apply_init_wr_i, .apply_init_lane_mask_i, .deinit_wr_i, .lane_deinit_mask_i,
        .flag_rd_i);
    // Fields of w bits: lanes in mk take value v
    function automatic logic [31:0] put(logic [31:0] b, logic [7:0] mk, int w, logic [3:0] v);
        for (int i = 0; i < 8; i++)
            for (int j = 0; j < w; j++)
                if (mk[i]) b[w*i+j] = v[j];
        return b;
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        seed = $urandom(3907);
        repeat (8) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        chk("active", active_app_o, 32'h1111_1111);
        chk("staged", staged_app_o, 32'h1111_1111);
        chk("deinit", lane_deinit_mask_o, 32'h0000_0000);
        h.pulse(2, 8'hFF, 4'h0);
        chk("hold", lane_deinit_mask_o, 32'h0000_00FF);
        module_ready_state_i = 1'b1;
        code = 4'($urandom_range(15, 2));
        m = {4'h0, 4'($urandom_range(15, 1))};
        supported_apps_i = 16'($urandom) & 16'hFFFE | 16'h0001 << code;
        for (int i = 0; i < 8; i++)
            if (m[i]) h.pulse(0, 8'(i), code);
        h.pulse(0, 8'h07, 4'h0);
        chk("staged", staged_app_o, put(32'h0111_1111, m, 4, code));
        // Host transmitters are taken as valid from here on
        h.pulse(1, m, 4'h0);
        chk("busy", config_status_fields_o, put(0, m, 2, 4'h3));
        // Second apply lands mid-sequence and must be dropped
        h.pulse(1, 8'h40, 4'h0);
        @(posedge clk_sys_i);
        #1 chk("status", config_status_fields_o, put(0, m, 2, 4'h1));
        chk("active", active_app_o, put(32'h1111_1111, m, 4, code));
        chk("pending", init_pending_bits_o, m);
        h.pulse(1, 8'h80, 4'h0);
        repeat (3) @(posedge clk_sys_i);
        #1 chk("reject", config_status_fields_o, put(put(0, m, 2, 4'h1), 8'h80, 2, 4'h2));
        chk("kept", active_app_o, put(32'h1111_1111, m, 4, code));
        h.pulse(2, lane_deinit_mask_o & ~m, 4'h0);
        for (int i = 0; i < 60 && interrupt_o !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("irq", interrupt_o, 1'b1);
        chk("state", path_state_o, put(0, m, 2, 4'h2));
        chk("flags", path_state_changed_flag_o, m);
        chk("pending", init_pending_bits_o, 0);
        h.pulse(3, 8'h00, 4'h0);
        chk("cleared", {interrupt_o, path_state_changed_flag_o}, 0);
        close_out;
    end
endmodule
`default_nettype wire
